// File: rtl/rsef_top.sv
// Implementation choice: the address-and-strobe port.
`include "rsef_map.svh"
module rsef_top (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [7:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_write,
   input wire logic bus_read,
   output logic [7:0] bus_rdata,
   input wire logic [7:0] rx_status_in,
   input wire logic conv_too_slow,
   input wire logic conv_left_limit,
   input wire logic conv_right_limit,
   input wire logic conv_muted,
   output logic rx_error_irq,
   output logic conv_error_irq
);
   // ************************************************************
   // address decode
   // ************************************************************
   function automatic logic hit(input rsef_pkg::rsef_addr_type a, input rsef_pkg::rsef_addr_type ofs);
      hit = (a == ofs);
   endfunction : hit

   logic rx_read;
   logic cv_read;
   // a read of the error register is what clears the sticky bits
   assign rx_read = bus_read & hit(bus_addr, `RSEF_RX_ERR_OFS);
   assign cv_read = bus_read & hit(bus_addr, `RSEF_CONV_ERR_OFS);

   // ************************************************************
   // flag banks
   // ************************************************************
   logic [7:0] rx_flags;
   logic [7:0] rx_pend;
   logic [7:0] cv_flags;
   logic [7:0] cv_pend;
   logic [7:0] cv_raw;
   // clock-shortage and mute are level flags; overranges latch
   assign cv_raw = {4'h0, conv_too_slow, conv_left_limit, conv_right_limit, conv_muted};

   rsef_flag_bank #(.sticky(`RSEF_RX_STICKY)) u_rx (
      .clock(clock),
      .rstn(rstn),
      .raw(rx_status_in),
      .rd_clear(rx_read),
      .flags(rx_flags),
      .pend(rx_pend)
   );

   rsef_flag_bank #(.sticky(`RSEF_CV_STICKY)) u_cv (
      .clock(clock),
      .rstn(rstn),
      .raw(cv_raw),
      .rd_clear(cv_read),
      .flags(cv_flags),
      .pend(cv_pend)
   );

   // ************************************************************
   // mask registers and read port
   // ************************************************************
   rsef_pkg::rsef_byte_type rx_mask;
   rsef_pkg::rsef_byte_type cv_mask;
   rsef_pkg::rsef_byte_type next_rx_mask;
   rsef_pkg::rsef_byte_type next_cv_mask;
   rsef_pkg::rsef_byte_type next_rdata;
   logic next_rx_irq;
   logic next_cv_irq;

   // writes land in the masks; unmapped reads return zero
   always_comb begin
      next_rx_mask = rx_mask;
      next_cv_mask = cv_mask;
      next_rdata = 8'h00;
      if (bus_write && hit(bus_addr, `RSEF_RX_MASK_OFS)) begin
         next_rx_mask = bus_wdata & `RSEF_RX_MASK_BITS;
      end
      if (bus_write && hit(bus_addr, `RSEF_CONV_MASK_OFS)) begin
         next_cv_mask = bus_wdata & `RSEF_CV_MASK_BITS;
      end
      if (bus_read) begin
         unique case (bus_addr)
            `RSEF_RX_ERR_OFS: next_rdata = rx_flags;
            `RSEF_RX_MASK_OFS: next_rdata = rx_mask;
            `RSEF_CONV_ERR_OFS: next_rdata = cv_flags;
            `RSEF_CONV_MASK_OFS: next_rdata = cv_mask;
            default: next_rdata = 8'h00;
         endcase
      end
      // the clock-shortage bit has no mask bit, so it never interrupts
      next_rx_irq = |(rx_pend & rx_mask);
      next_cv_irq = |(cv_pend & cv_mask);
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rx_mask <= `RSEF_MASK_RESET;
         cv_mask <= `RSEF_MASK_RESET;
         bus_rdata <= 8'h00;
         rx_error_irq <= 1'b0;
         conv_error_irq <= 1'b0;
      end else begin
         rx_mask <= next_rx_mask;
         cv_mask <= next_cv_mask;
         bus_rdata <= next_rdata;
         rx_error_irq <= next_rx_irq;
         conv_error_irq <= next_cv_irq;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   chk_slow_follows: assert property (@(posedge clock) disable iff (!rstn)
      conv_too_slow |=> cv_flags[`RSEF_CV_SLOW_BIT]) else $error("slow flag missed");
   chk_left_overrange_hold: assert property (@(posedge clock) disable iff (!rstn)
      cv_flags[`RSEF_CV_LEFT_OVERRANGE_BIT] && !cv_read |=> cv_flags[`RSEF_CV_LEFT_OVERRANGE_BIT]) else $error("left_overrange lost");
   chk_left_overrange_set: assert property (@(posedge clock) disable iff (!rstn)
      conv_left_limit |=> cv_flags[`RSEF_CV_LEFT_OVERRANGE_BIT]) else $error("left_overrange not set");
   chk_right_overrange_hold: assert property (@(posedge clock) disable iff (!rstn)
      cv_flags[`RSEF_CV_RIGHT_OVERRANGE_BIT] && !cv_read |=> cv_flags[`RSEF_CV_RIGHT_OVERRANGE_BIT]) else $error("right_overrange lost");
   chk_right_overrange_set: assert property (@(posedge clock) disable iff (!rstn)
      conv_right_limit |=> cv_flags[`RSEF_CV_RIGHT_OVERRANGE_BIT]) else $error("right_overrange not set");
   chk_mute_level: assert property (@(posedge clock) disable iff (!rstn)
      1'b1 |=> cv_flags[`RSEF_CV_MUTE_BIT] == $past(conv_muted)) else $error("mute flag wrong");
   chk_mask_gate: assert property (@(posedge clock) disable iff (!rstn)
      (cv_pend & cv_mask) == 8'h00 |=> !conv_error_irq) else $error("masked irq seen");
   chk_rx_irq_up: assert property (@(posedge clock) disable iff (!rstn)
      (rx_pend & rx_mask) != 8'h00 |=> rx_error_irq) else $error("rx irq missed");
   chk_crc_hold: assert property (@(posedge clock) disable iff (!rstn)
      rx_flags[`RSEF_RX_CRC_BIT] && !rx_read |=> rx_flags[`RSEF_RX_CRC_BIT]) else $error("crc lost");
   chk_absent_quiet: assert property (@(posedge clock) disable iff (!rstn)
      rx_read && $stable(rx_status_in[`RSEF_RX_ABSENT_BIT]) ##1 $stable(rx_status_in[`RSEF_RX_ABSENT_BIT])
      |-> !rx_pend[`RSEF_RX_ABSENT_BIT]) else $error("absent event repeated");

   // ************************************************************
   // read port checks
   // ************************************************************
   // read data stand one cycle only, so an idle cycle must show zero
   chk_rdata_idle: assert property (@(posedge clock) disable iff (!rstn)
      !bus_read |=> bus_rdata == 8'h00)
      else $error("read data not zero when idle");

   // receiver mask read back
   chk_rdata_rxmask: assert property (@(posedge clock) disable iff (!rstn)
      bus_read && bus_addr == `RSEF_RX_MASK_OFS |=> bus_rdata == $past(rx_mask))
      else $error("rx mask read wrong");

   // converter mask read back
   chk_rdata_cvmask: assert property (@(posedge clock) disable iff (!rstn)
      bus_read && bus_addr == `RSEF_CONV_MASK_OFS |=> bus_rdata == $past(cv_mask))
      else $error("conv mask read wrong");

   // receiver flags are returned as they stood before the clear
   chk_rdata_rxflags: assert property (@(posedge clock) disable iff (!rstn)
      bus_read && bus_addr == `RSEF_RX_ERR_OFS |=> bus_rdata == $past(rx_flags))
      else $error("rx flags read wrong");

   // converter flags are returned as they stood before the clear
   chk_rdata_cvflags: assert property (@(posedge clock) disable iff (!rstn)
      bus_read && bus_addr == `RSEF_CONV_ERR_OFS |=> bus_rdata == $past(cv_flags))
      else $error("conv flags read wrong");

   // unmapped offsets read as zero so software sees no stale data
   chk_rdata_unmapped: assert property (@(posedge clock) disable iff (!rstn)
      bus_read && (bus_addr < `RSEF_RX_ERR_OFS || bus_addr > `RSEF_CONV_MASK_OFS) |=> bus_rdata == 8'h00)
      else $error("unmapped read not zero");

   // ************************************************************
   // mask register checks
   // ************************************************************
   // converter mask has only three implemented bits
   chk_cvmask_top: assert property (@(posedge clock) disable iff (!rstn)
      cv_mask[7:3] == 5'h00)
      else $error("conv mask spare bits set");

   // a write lands in the receiver mask
   chk_rxmask_write: assert property (@(posedge clock) disable iff (!rstn)
      bus_write && bus_addr == `RSEF_RX_MASK_OFS |=> rx_mask == $past(bus_wdata))
      else $error("rx mask write lost");

   // a write lands in the converter mask, spare bits dropped
   chk_cvmask_write: assert property (@(posedge clock) disable iff (!rstn)
      bus_write && bus_addr == `RSEF_CONV_MASK_OFS |=> cv_mask == ($past(bus_wdata) & `RSEF_CV_MASK_BITS))
      else $error("conv mask write lost");

   // the receiver mask keeps its value without a write to it
   chk_rxmask_keep: assert property (@(posedge clock) disable iff (!rstn)
      !(bus_write && bus_addr == `RSEF_RX_MASK_OFS) |=> $stable(rx_mask))
      else $error("rx mask changed");

   // the converter mask keeps its value without a write to it
   chk_cvmask_keep: assert property (@(posedge clock) disable iff (!rstn)
      !(bus_write && bus_addr == `RSEF_CONV_MASK_OFS) |=> $stable(cv_mask))
      else $error("conv mask changed");

   // ************************************************************
   // converter flag checks
   // ************************************************************
   // clock shortage is a level flag and drops with its cause
   chk_slow_clear: assert property (@(posedge clock) disable iff (!rstn)
      !conv_too_slow |=> !cv_flags[`RSEF_CV_SLOW_BIT])
      else $error("slow flag stuck");

   // reserved converter bits always read zero
   chk_cv_top_zero: assert property (@(posedge clock) disable iff (!rstn)
      cv_flags[7:4] == 4'h0)
      else $error("conv reserved bits set");

   // left overrange clears on a read when no new limiting arrives
   chk_left_overrange_clear: assert property (@(posedge clock) disable iff (!rstn)
      cv_read && !conv_left_limit |=> !cv_flags[`RSEF_CV_LEFT_OVERRANGE_BIT])
      else $error("left_overrange not cleared");

   // right overrange clears on a read when no new limiting arrives
   chk_right_overrange_clear: assert property (@(posedge clock) disable iff (!rstn)
      cv_read && !conv_right_limit |=> !cv_flags[`RSEF_CV_RIGHT_OVERRANGE_BIT])
      else $error("right_overrange not cleared");

   // left limiting always leaves an event behind
   chk_left_overrange_event: assert property (@(posedge clock) disable iff (!rstn)
      conv_left_limit |=> cv_pend[`RSEF_CV_LEFT_OVERRANGE_BIT])
      else $error("left_overrange event missed");

   // right limiting always leaves an event behind
   chk_right_overrange_event: assert property (@(posedge clock) disable iff (!rstn)
      conv_right_limit |=> cv_pend[`RSEF_CV_RIGHT_OVERRANGE_BIT])
      else $error("right_overrange event missed");

   // an unmasked mute event reaches the interrupt
   chk_mute_irq: assert property (@(posedge clock) disable iff (!rstn)
      cv_pend[`RSEF_CV_MUTE_BIT] && cv_mask[`RSEF_CV_MUTE_BIT] |=> conv_error_irq)
      else $error("mute irq missed");

   // ************************************************************
   // interrupt checks
   // ************************************************************
   // any unmasked converter event raises the interrupt
   chk_cv_irq_up: assert property (@(posedge clock) disable iff (!rstn)
      (cv_pend & cv_mask) != 8'h00 |=> conv_error_irq)
      else $error("conv irq missed");

   // masked receiver events stay silent
   chk_rx_mask_gate: assert property (@(posedge clock) disable iff (!rstn)
      (rx_pend & rx_mask) == 8'h00 |=> !rx_error_irq)
      else $error("masked rx irq seen");

   // an all-zero receiver mask keeps the line low
   chk_rx_irq_off: assert property (@(posedge clock) disable iff (!rstn)
      rx_mask == 8'h00 |=> !rx_error_irq)
      else $error("rx irq with zero mask");

   // an all-zero converter mask keeps the line low
   chk_cv_irq_off: assert property (@(posedge clock) disable iff (!rstn)
      cv_mask == 8'h00 |=> !conv_error_irq)
      else $error("conv irq with zero mask");

   // ************************************************************
   // receiver flag checks
   // ************************************************************
   // a checksum error is caught one cycle later
   chk_crc_set: assert property (@(posedge clock) disable iff (!rstn)
      rx_status_in[`RSEF_RX_CRC_BIT] |=> rx_flags[`RSEF_RX_CRC_BIT])
      else $error("crc not set");

   // the checksum flag clears on a read when the error is gone
   chk_crc_clear: assert property (@(posedge clock) disable iff (!rstn)
      rx_read && !rx_status_in[`RSEF_RX_CRC_BIT] |=> !rx_flags[`RSEF_RX_CRC_BIT])
      else $error("crc not cleared");

   // the absent-stream flag follows its input one cycle late
   chk_absent_level: assert property (@(posedge clock) disable iff (!rstn)
      1'b1 |=> rx_flags[`RSEF_RX_ABSENT_BIT] == $past(rx_status_in[`RSEF_RX_ABSENT_BIT]))
      else $error("absent flag wrong");

   // a change of the absent-stream state is always an event
   chk_absent_event: assert property (@(posedge clock) disable iff (!rstn)
      $changed(rx_status_in[`RSEF_RX_ABSENT_BIT]) |=> rx_pend[`RSEF_RX_ABSENT_BIT])
      else $error("absent change missed");

   // validity error latches until read
   chk_valid_set: assert property (@(posedge clock) disable iff (!rstn)
      rx_status_in[`RSEF_RX_VALID_BIT] |=> rx_flags[`RSEF_RX_VALID_BIT])
      else $error("validity not set");

   // validity error holds without a read
   chk_valid_hold: assert property (@(posedge clock) disable iff (!rstn)
      rx_flags[`RSEF_RX_VALID_BIT] && !rx_read |=> rx_flags[`RSEF_RX_VALID_BIT])
      else $error("validity lost");

   // biphase or parity error latches
   chk_bipar_set: assert property (@(posedge clock) disable iff (!rstn)
      rx_status_in[`RSEF_RX_BIPAR_BIT] |=> rx_flags[`RSEF_RX_BIPAR_BIT])
      else $error("biphase not set");

   // biphase or parity error holds without a read
   chk_bipar_hold: assert property (@(posedge clock) disable iff (!rstn)
      rx_flags[`RSEF_RX_BIPAR_BIT] && !rx_read |=> rx_flags[`RSEF_RX_BIPAR_BIT])
      else $error("biphase lost");

   // emphasis is a level bit
   chk_emph_level: assert property (@(posedge clock) disable iff (!rstn)
      1'b1 |=> rx_flags[`RSEF_RX_EMPH_BIT] == $past(rx_status_in[`RSEF_RX_EMPH_BIT]))
      else $error("emphasis flag wrong");

   // non-audio is a level bit
   chk_nonaud_level: assert property (@(posedge clock) disable iff (!rstn)
      1'b1 |=> rx_flags[`RSEF_RX_NONAUD_BIT] == $past(rx_status_in[`RSEF_RX_NONAUD_BIT]))
      else $error("non-audio flag wrong");

   // preamble detection is a level bit
   chk_preamb_level: assert property (@(posedge clock) disable iff (!rstn)
      1'b1 |=> rx_flags[`RSEF_RX_PREAMB_BIT] == $past(rx_status_in[`RSEF_RX_PREAMB_BIT]))
      else $error("preamble flag wrong");

   // lock is a level bit; a read must not disturb it
   chk_lock_level: assert property (@(posedge clock) disable iff (!rstn)
      1'b1 |=> rx_flags[`RSEF_RX_LOCK_BIT] == $past(rx_status_in[`RSEF_RX_LOCK_BIT]))
      else $error("lock flag wrong");
endmodule : rsef_top

// File: rtl/rsef_map.svh
`ifndef RSEF_MAP_SVH
`define RSEF_MAP_SVH
// ************************************************************
// register offsets
// ************************************************************
`define RSEF_RX_ERR_OFS 8'h18
`define RSEF_RX_MASK_OFS 8'h19
`define RSEF_CONV_ERR_OFS 8'h1a
`define RSEF_CONV_MASK_OFS 8'h1b
// ************************************************************
// field positions
// ************************************************************
`define RSEF_RX_VALID_BIT 7
`define RSEF_RX_EMPH_BIT 6
`define RSEF_RX_NONAUD_BIT 5
`define RSEF_RX_PREAMB_BIT 4
`define RSEF_RX_CRC_BIT 3
`define RSEF_RX_ABSENT_BIT 2
`define RSEF_RX_BIPAR_BIT 1
`define RSEF_RX_LOCK_BIT 0
`define RSEF_CV_SLOW_BIT 3
`define RSEF_CV_LEFT_OVERRANGE_BIT 2
`define RSEF_CV_RIGHT_OVERRANGE_BIT 1
`define RSEF_CV_MUTE_BIT 0
// ************************************************************
// reset values and masks of implemented bits
// ************************************************************
`define RSEF_MASK_RESET 8'h00
`define RSEF_RX_MASK_BITS 8'hff
`define RSEF_CV_MASK_BITS 8'h07
// sticky receiver bits: validity, checksum, biphase/parity
`define RSEF_RX_STICKY 8'h8a
`define RSEF_CV_STICKY 8'h06
`endif

// File: rtl/rsef_pkg.sv
package rsef_pkg;
   typedef logic [7:0] rsef_byte_type;
   typedef logic [7:0] rsef_addr_type;
endpackage : rsef_pkg

// File: rtl/rsef_flag_bank.sv
`include "rsef_map.svh"
// ************************************************************
// eight status bits: sticky or level; sticky bits raise events while set, level bits on change
// ************************************************************
module rsef_flag_bank #(
   parameter logic [7:0] sticky = 8'h00
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [7:0] raw,
   input wire logic rd_clear,
   output logic [7:0] flags,
   output logic [7:0] pend
);
   logic [7:0] next_flags;
   logic [7:0] next_pend;
   logic [7:0] last_raw;
   genvar i;
   // per bit: sticky bits latch, level bits follow; pend marks an unread set (sticky) or change (level)
   generate
      for (i = 0; i < 8; i++) begin : g_bit
         always_comb begin
            if (sticky[i]) begin
               // set wins over the read clear
               next_flags[i] = raw[i] | (flags[i] & ~rd_clear);
               next_pend[i] = raw[i] | (pend[i] & ~rd_clear);
            end else begin
               next_flags[i] = raw[i];
               // a level bit only raises a new event when it changes state
               next_pend[i] = (raw[i] != last_raw[i]) | (pend[i] & ~rd_clear);
            end
         end
      end
   endgenerate
   // registers only
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         flags <= 8'h00;
         pend <= 8'h00;
         last_raw <= 8'h00;
      end else begin
         flags <= next_flags;
         pend <= next_pend;
         last_raw <= raw;
      end
   end
endmodule : rsef_flag_bank

// File: verif/rsef_top_bench.sv
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
   $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module rsef_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   rsef_pkg::rsef_addr_type bus_addr = 8'h00;
   rsef_pkg::rsef_byte_type bus_wdata = 8'h00, bus_rdata, rx_status_in = 8'h00, d;
   logic bus_write = 1'b0, bus_read = 1'b0, conv_too_slow = 1'b0, conv_left_limit = 1'b0;
   logic conv_right_limit = 1'b0, conv_muted = 1'b0, rx_error_irq, conv_error_irq;
   int failures = 0;
   int check_count = 0;
   rsef_top DUT (.clock(clock), .rstn(rstn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata), .rx_status_in(rx_status_in),
      .conv_too_slow(conv_too_slow), .conv_left_limit(conv_left_limit), .conv_right_limit(conv_right_limit),
      .conv_muted(conv_muted), .rx_error_irq(rx_error_irq), .conv_error_irq(conv_error_irq));
   // ************************************************************
   // clock, bus tasks and verdict
   // ************************************************************
   // 50 mhz system clock
   initial begin
      forever #10 clock = ~clock;
   end
   // one-cycle write strobe; the lowering edge is the taking edge
   task wr(input rsef_pkg::rsef_addr_type a, input rsef_pkg::rsef_byte_type v);
      @(posedge clock) bus_addr <= a;
      bus_wdata <= v;
      bus_write <= 1'b1;
      @(posedge clock) bus_write <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe, so sample just past that edge
   task rd(input rsef_pkg::rsef_addr_type a, output rsef_pkg::rsef_byte_type v);
      @(posedge clock) bus_addr <= a;
      bus_read <= 1'b1;
      @(posedge clock) bus_read <= 1'b0;
      #1 v = bus_rdata;
   endtask : rd
   // raw to irq takes two cycles, three leaves margin
   task step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : step
   task results;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : results
   // watchdog: the sequence needs well under a thousand cycles
   initial begin
      #200000;
      failures++;
      results;
   end
   // ************************************************************
   // test sequence
   // ************************************************************
   initial begin
      repeat (12) @(posedge clock);
      rstn <= 1'b1;
      step(1);
      `CHK("irqs after reset", 2'b00, {rx_error_irq, conv_error_irq})
      rd(8'h19, d); `CHK("rx mask reset", 8'h00, d)
      rd(8'h1b, d); `CHK("conv mask reset", 8'h00, d)
      rd(8'h1a, d); `CHK("conv flags reset", 8'h00, d)
      wr(8'h19, 8'hff); rd(8'h19, d); `CHK("rx mask rw", 8'hff, d)
      wr(8'h1b, 8'hff); rd(8'h1b, d); `CHK("conv mask bits", 8'h07, d)
      wr(8'h1a, 8'hff); rd(8'h1a, d); `CHK("conv flags read only", 8'h00, d)
      rd(8'h55, d); `CHK("unmapped read", 8'h00, d)
      rd(8'h19, d); step(1); `CHK("rdata back to zero", 8'h00, bus_rdata)
      // masked source: flag is held but no interrupt
      wr(8'h1b, 8'h00);
      @(posedge clock) conv_left_limit <= 1'b1;
      @(posedge clock) conv_left_limit <= 1'b0;
      step(3); `CHK("masked irq", 1'b0, conv_error_irq)
      rd(8'h1a, d); `CHK("left held", 8'h04, d)
      rd(8'h1a, d); `CHK("left cleared", 8'h00, d)
      wr(8'h1b, 8'h07);
      @(posedge clock) conv_right_limit <= 1'b1;
      @(posedge clock) conv_right_limit <= 1'b0;
      step(3); `CHK("unmasked irq", 1'b1, conv_error_irq)
      rd(8'h1a, d); `CHK("right held", 8'h02, d)
      rd(8'h1a, d); `CHK("right cleared", 8'h00, d)
      step(2); `CHK("irq after read", 1'b0, conv_error_irq)
      // clock shortage has no mask bit, so it never interrupts
      @(posedge clock) conv_too_slow <= 1'b1;
      step(3); rd(8'h1a, d); `CHK("too slow flag", 8'h08, d)
      `CHK("too slow no irq", 1'b0, conv_error_irq)
      @(posedge clock) conv_too_slow <= 1'b0;
      @(posedge clock) conv_muted <= 1'b1;
      step(3); `CHK("mute irq", 1'b1, conv_error_irq)
      rd(8'h1a, d); `CHK("mute flag", 8'h01, d)
      step(2); `CHK("mute irq cleared", 1'b0, conv_error_irq)
      rd(8'h1a, d); `CHK("mute level stays", 8'h01, d)
      @(posedge clock) conv_muted <= 1'b0;
      // receiver checksum error pulse is held until read
      wr(8'h19, 8'h08);
      @(posedge clock) rx_status_in <= 8'h08;
      @(posedge clock) rx_status_in <= 8'h00;
      step(3); `CHK("crc irq", 1'b1, rx_error_irq)
      rd(8'h18, d); `CHK("crc held", 8'h08, d)
      rd(8'h18, d); `CHK("crc cleared", 8'h00, d)
      step(2); `CHK("crc irq cleared", 1'b0, rx_error_irq)
      // absent stream: one event per change of state
      wr(8'h19, 8'h04);
      @(posedge clock) rx_status_in <= 8'h04;
      step(3); `CHK("absent irq", 1'b1, rx_error_irq)
      rd(8'h18, d); `CHK("absent flag", 8'h04, d)
      step(2); `CHK("no new absent irq", 1'b0, rx_error_irq)
      rd(8'h18, d); `CHK("absent stays", 8'h04, d)
      @(posedge clock) rx_status_in <= 8'h00;
      step(3); `CHK("absent change irq", 1'b1, rx_error_irq)
      results;
   end
endmodule : rsef_top_bench
